// ===== rtl/bkpu_breakpoint_unit.sv
// Summary of operation
// - Enabled break with fetch address equal to break address raises request.
// - On break, instruction register takes the software interrupt opcode.
// - Break vector FFFC/FFFD normally, FEFC/FEFD in monitor mode.
// - Writing one to break-active bit breaks before the next instruction.
// - Opcode address match: instruction waits until handler completes.
// - Operand address match: instruction completes before the break.
// - Return from interrupt in handler ends break state.
// - Cleared active bit with unchanged address gives no break on exit.
// - Enable bit gates 16-bit match; cleared by reset or writing zero.
// - Active bit set on match, cleared by writing zero or reset.
// - Break address high and low bytes are read-write, reset to zero.
// - Flag-clear-enable zero protects status bits during break state.
// - Timer counter halted while break is in progress.
// - Watchdog disable bit holds watchdog off in monitor-mode break.
// - Wait-exit flag reads one when wait left by break.
// - Wait-exit status register works only in emulation mode.
// - Unit stays enabled in wait and stop; no address match fires.
`timescale 1ns/1ps
`default_nettype none
module bkpu_breakpoint_unit (
    input wire logic SYS_CLK, // 10 MHz bus clock
    input wire logic RSTN, // Async reset, active low
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB access phase
    input wire logic PWRITE, // APB direction
    input wire logic [7:0] PADDR, // APB byte address
    input wire logic [31:0] PWDATA, // APB write data
    output logic [31:0] PRDATA, // APB read data
    output logic PREADY, // APB ready
    output logic PSLVERR, // APB error, unmapped address
    input wire logic [15:0] CPU_ADDR, // Core program counter address
    input wire logic CPU_OPCODE_FETCH, // Current fetch is an opcode
    input wire logic CPU_INSTR_START, // Next instruction about to start
    input wire logic CPU_RTI_DONE, // Return from interrupt completed
    input wire logic MONITOR_MODE, // Device in monitor mode
    input wire logic EMULATION_MODE, // Device in emulation mode
    input wire logic WAIT_EXIT, // Wait mode left this cycle
    input wire logic LOW_POWER, // Wait or stop mode active
    output logic BREAKPOINT_REQUEST, // Break request to integration logic
    output logic FORCE_SWI, // Load interrupt opcode into IR
    output logic [7:0] FORCED_OPCODE, // Opcode to load
    output logic [15:0] BREAK_VECTOR, // Vector address for handler
    output logic BREAK_STATE, // Break handler in progress
    output logic TIMER_HALT, // Halt timer counter
    output logic WATCHDOG_HOLD, // Hold watchdog disabled
    output logic STATUS_CLEAR_ALLOWED // Status flags may be cleared
);
    logic rst_meta_q, rst_sync_q;
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    wire rst_n = rst_sync_q;

    bkpu_pkg::bkpu_cpu_t cpu;
    assign cpu = '{addr: CPU_ADDR, opcode_fetch: CPU_OPCODE_FETCH,
                   instr_start: CPU_INSTR_START, rti_done: CPU_RTI_DONE};

    logic enable_q, active_q, wdog_dis_q, flag_clr_q, wait_exit_q;
    logic armed_q;
    logic [7:0] addr_high_q, addr_low_q;
    bkpu_pkg::bkpu_state_t state_q, state_d;
    logic [31:0] rdata_d;

    wire wr = PSEL && PENABLE && PWRITE;
    wire rd = PSEL && PENABLE && !PWRITE;
    wire sel_sc = PADDR == bkpu_pkg::ADDR_STATUS_CONTROL;
    wire sel_hi = PADDR == bkpu_pkg::ADDR_ADDRESS_HIGH;
    wire sel_lo = PADDR == bkpu_pkg::ADDR_ADDRESS_LOW;
    wire sel_ax = PADDR == bkpu_pkg::ADDR_AUXILIARY;
    wire sel_ws = PADDR == bkpu_pkg::ADDR_WAIT_STATUS;
    wire sel_fc = PADDR == bkpu_pkg::ADDR_FLAG_CONTROL;
    wire mapped = sel_sc | sel_hi | sel_lo | sel_ax | sel_ws | sel_fc;
    wire wr_sc = wr && sel_sc;
    wire [7:0] wbyte = PWDATA[7:0];

    wire [15:0] break_addr = {addr_high_q, addr_low_q};

    // Every bit must agree; no byte of the address may match on its own
    wire [15:0] bit_eq;
    for (genvar b = 0; b < 16; b = b + 1) begin : g_cmp
        assign bit_eq[b] = cpu.addr[b] == break_addr[b];
    end
    wire addr_equal = &bit_eq;

    // Low-power modes freeze the address bus, so gating here is harmless
    wire addr_match = enable_q && !active_q && armed_q && !LOW_POWER
                      && addr_equal;

    // A match disarms the compare until software rewrites an address byte,
    // so clearing only the active bit cannot retrigger on the way out
    wire addr_written = wr && (sel_hi || sel_lo);
    wire armed_d = addr_written || (armed_q && !addr_match);
    // Software request counts only from idle so a handler write does not rebreak
    wire sw_break = wr_sc && wbyte[bkpu_pkg::ACTIVE_BIT]
                    && state_q == bkpu_pkg::BKPU_IDLE;

    // Set beats the clear when a match lands on the write cycle
    wire active_set = addr_match || sw_break;
    wire active_clr = wr_sc && !wbyte[bkpu_pkg::ACTIVE_BIT];

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            enable_q <= 1'b0;
        end else if (wr_sc) begin
            enable_q <= wbyte[bkpu_pkg::ENABLE_BIT];
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            active_q <= 1'b0;
        end else if (active_set) begin
            active_q <= 1'b1;
        end else if (active_clr) begin
            active_q <= 1'b0;
        end
    end

    // Reset arms the compare so the first programmed address can fire
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            armed_q <= 1'b1;
        end else begin
            armed_q <= armed_d;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            addr_high_q <= bkpu_pkg::RESET_BYTE;
        end else if (wr && sel_hi) begin
            addr_high_q <= wbyte;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            addr_low_q <= bkpu_pkg::RESET_BYTE;
        end else if (wr && sel_lo) begin
            addr_low_q <= wbyte;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            wdog_dis_q <= 1'b0;
        end else if (wr && sel_ax) begin
            wdog_dis_q <= wbyte[bkpu_pkg::WDOG_DIS_BIT];
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            flag_clr_q <= 1'b0;
        end else if (wr && sel_fc) begin
            flag_clr_q <= wbyte[bkpu_pkg::FLAG_CLR_BIT];
        end
    end

    // Wait-exit flag only tracks in emulation mode; cleared by writing zero
    wire wait_set = EMULATION_MODE && WAIT_EXIT && state_q != bkpu_pkg::BKPU_IDLE;
    wire wait_clr = wr && sel_ws && !wbyte[bkpu_pkg::WAIT_EXIT_BIT];
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            wait_exit_q <= 1'b0;
        end else if (wait_set) begin
            wait_exit_q <= 1'b1;
        end else if (wait_clr) begin
            wait_exit_q <= 1'b0;
        end
    end

    // A pending break is taken only at an instruction boundary: opcode
    // matches hold the instruction back, operand matches let it finish
    wire opcode_hit = addr_match && cpu.opcode_fetch;
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            bkpu_pkg::BKPU_IDLE: begin
                if (opcode_hit) begin
                    state_d = bkpu_pkg::BKPU_BREAK;
                end else if (active_set) begin
                    state_d = bkpu_pkg::BKPU_PEND;
                end
            end
            bkpu_pkg::BKPU_PEND: begin
                if (cpu.instr_start) begin
                    state_d = bkpu_pkg::BKPU_BREAK;
                end
            end
            bkpu_pkg::BKPU_BREAK: begin
                if (cpu.rti_done) begin
                    state_d = bkpu_pkg::BKPU_IDLE;
                end
            end
            default: state_d = bkpu_pkg::BKPU_IDLE;
        endcase
    end

    wire enter_break = state_q != bkpu_pkg::BKPU_BREAK
                       && state_d == bkpu_pkg::BKPU_BREAK;
    wire in_break_d = state_d == bkpu_pkg::BKPU_BREAK;
    wire [15:0] vector_d = MONITOR_MODE ? bkpu_pkg::VECTOR_MONITOR
                                        : bkpu_pkg::VECTOR_NORMAL;
    wire wdog_hold_d = in_break_d && MONITOR_MODE && wdog_dis_q;
    // Outside a break the status flags always clear as usual
    wire clr_allowed_d = !in_break_d || flag_clr_q;

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= bkpu_pkg::BKPU_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            BREAKPOINT_REQUEST <= 1'b0;
        end else begin
            BREAKPOINT_REQUEST <= enter_break;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            FORCE_SWI <= 1'b0;
        end else begin
            FORCE_SWI <= enter_break;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            FORCED_OPCODE <= bkpu_pkg::SWI_OPCODE;
        end else begin
            FORCED_OPCODE <= bkpu_pkg::SWI_OPCODE;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            BREAK_VECTOR <= bkpu_pkg::VECTOR_NORMAL;
        end else begin
            BREAK_VECTOR <= vector_d;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            BREAK_STATE <= 1'b0;
        end else begin
            BREAK_STATE <= in_break_d;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            TIMER_HALT <= 1'b0;
        end else begin
            TIMER_HALT <= in_break_d;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            WATCHDOG_HOLD <= 1'b0;
        end else begin
            WATCHDOG_HOLD <= wdog_hold_d;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            STATUS_CLEAR_ALLOWED <= 1'b1;
        end else begin
            STATUS_CLEAR_ALLOWED <= clr_allowed_d;
        end
    end

    always_comb begin
        rdata_d = 32'h00000000;
        if (sel_sc) begin
            rdata_d[bkpu_pkg::ENABLE_BIT] = enable_q;
            rdata_d[bkpu_pkg::ACTIVE_BIT] = active_q;
        end
        if (sel_hi) begin
            rdata_d[7:0] = addr_high_q;
        end
        if (sel_lo) begin
            rdata_d[7:0] = addr_low_q;
        end
        if (sel_ax) begin
            rdata_d[bkpu_pkg::WDOG_DIS_BIT] = wdog_dis_q;
        end
        if (sel_ws) begin
            rdata_d[bkpu_pkg::WAIT_EXIT_BIT] = wait_exit_q;
        end
        if (sel_fc) begin
            rdata_d[bkpu_pkg::FLAG_CLR_BIT] = flag_clr_q;
        end
    end

    // Zero-wait-state slave: PREADY rises at the first edge after the
    // internal reset lifts and then stays high, so every access is one cycle
    wire setup_phase = PSEL && !PENABLE;

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            PREADY <= 1'b0;
        end else begin
            PREADY <= 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            PSLVERR <= 1'b0;
        end else begin
            PSLVERR <= setup_phase && !mapped;
        end
    end

    // Read data is captured in setup so it stands through the access phase
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            PRDATA <= 32'h00000000;
        end else if (setup_phase && !PWRITE) begin
            PRDATA <= rdata_d;
        end
    end
    wire unused_rd = rd;
endmodule : bkpu_breakpoint_unit
`default_nettype wire

// ===== rtl/bkpu_pkg.sv
package bkpu_pkg;
    localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_ADDRESS_HIGH = 8'h04;
    localparam logic [7:0] ADDR_ADDRESS_LOW = 8'h08;
    localparam logic [7:0] ADDR_AUXILIARY = 8'h0C;
    localparam logic [7:0] ADDR_WAIT_STATUS = 8'h10;
    localparam logic [7:0] ADDR_FLAG_CONTROL = 8'h14;
    localparam int ENABLE_BIT = 7;
    localparam int ACTIVE_BIT = 6;
    localparam int WDOG_DIS_BIT = 0;
    localparam int WAIT_EXIT_BIT = 1;
    localparam int FLAG_CLR_BIT = 7;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] VECTOR_NORMAL = 16'hFFFC;
    localparam logic [15:0] VECTOR_MONITOR = 16'hFEFC;
    localparam logic [7:0] SWI_OPCODE = 8'h83;

    typedef struct packed {
        logic [15:0] addr;
        logic opcode_fetch;
        logic instr_start;
        logic rti_done;
    } bkpu_cpu_t;

    typedef enum logic [1:0] {
        BKPU_IDLE = 2'b00,
        BKPU_PEND = 2'b01,
        BKPU_BREAK = 2'b11
    } bkpu_state_t;
endpackage : bkpu_pkg

// ===== tb/bkpu_chk.sv
`timescale 1ns/1ps
`default_nettype none
module bkpu_chk (
    input wire logic SYS_CLK, // Bus clock
    input wire logic RSTN, // Reset, active low
    input wire logic CPU_INSTR_START, // Instruction boundary
    input wire logic CPU_RTI_DONE, // Handler return
    input wire logic MONITOR_MODE, // Monitor mode
    input wire logic LOW_POWER, // Wait or stop
    input wire logic BREAKPOINT_REQUEST, // Break request
    input wire logic FORCE_SWI, // Opcode force
    input wire logic [15:0] BREAK_VECTOR, // Handler vector
    input wire logic BREAK_STATE, // In break
    input wire logic TIMER_HALT, // Timer halt
    input wire logic WATCHDOG_HOLD, // Watchdog held off
    input wire logic STATUS_CLEAR_ALLOWED // Flags clearable
);
    default clocking @(posedge SYS_CLK);
    endclocking
    default disable iff (!RSTN);
    a_entry_req: assert property ($rose(BREAK_STATE) |-> BREAKPOINT_REQUEST)
        else $error("break entered without request");
    a_req_pulse: assert property (BREAKPOINT_REQUEST |=> !BREAKPOINT_REQUEST[*2])
        else $error("request longer than one cycle");
    a_swi_force: assert property (FORCE_SWI == BREAKPOINT_REQUEST)
        else $error("opcode force not aligned with request");
    a_vector_mode: assert property (BREAK_VECTOR == ($past(MONITOR_MODE) ?
        bkpu_pkg::VECTOR_MONITOR : bkpu_pkg::VECTOR_NORMAL))
        else $error("wrong break vector");
    a_rti_exit: assert property (BREAK_STATE && CPU_RTI_DONE |=> !BREAK_STATE)
        else $error("break state outlived return");
    a_flag_guard: assert property (!STATUS_CLEAR_ALLOWED |->
        BREAK_STATE || $past(BREAK_STATE))
        else $error("flags protected outside break");
    a_timer_halt: assert property (TIMER_HALT == BREAK_STATE)
        else $error("timer halt differs from break state");
    a_wdog_hold: assert property (WATCHDOG_HOLD |-> $past(MONITOR_MODE) &&
        (BREAK_STATE || $past(BREAK_STATE)))
        else $error("watchdog held outside monitor break");
    a_lowpwr_quiet: assert property ($past(LOW_POWER) &&
        !$past(CPU_INSTR_START) && !$past(BREAK_STATE) |-> !BREAKPOINT_REQUEST)
        else $error("match break fired in low power");
    c_mon_break: cover property (BREAKPOINT_REQUEST && MONITOR_MODE);
    c_wdog: cover property (WATCHDOG_HOLD);
    c_rti: cover property (BREAK_STATE && CPU_RTI_DONE);
endmodule : bkpu_chk
bind bkpu_breakpoint_unit bkpu_chk bkpu_chk_inst (.SYS_CLK, .RSTN,
    .CPU_INSTR_START, .CPU_RTI_DONE, .MONITOR_MODE, .LOW_POWER,
    .BREAKPOINT_REQUEST, .FORCE_SWI, .BREAK_VECTOR, .BREAK_STATE,
    .TIMER_HALT, .WATCHDOG_HOLD, .STATUS_CLEAR_ALLOWED);
`default_nettype wire

// ===== tb/bkpu_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module bkpu_cpu_model (
    input wire logic clk, // Bus clock
    input wire logic rst_n, // Reset, active low
    input wire logic force_swi, // Handler entry
    input wire logic [7:0] ret_dly, // Handler length in cycles
    output logic instr_start, // Boundary every fourth cycle
    output logic rti_done // Handler return pulse
);
    logic [7:0] cnt_q;
    logic [1:0] ph_q;
    logic busy_q;
    // No boundaries inside the handler, so soft breaks cannot stack
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {cnt_q, ph_q, busy_q, instr_start, rti_done} <= 13'h0;
        end else begin
            ph_q <= ph_q + 2'h1;
            instr_start <= (ph_q == 2'h3) && !busy_q;
            rti_done <= busy_q && (cnt_q == 8'h00);
            busy_q <= force_swi || (busy_q && cnt_q != 8'h00);
            cnt_q <= force_swi ? ret_dly : cnt_q - 8'h01;
        end
    end
endmodule : bkpu_cpu_model
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic SYS_CLK = 1'h0, RSTN = 1'h0, PSEL = 1'h0, PENABLE = 1'h0;
    logic PWRITE = 1'h0, CPU_OPCODE_FETCH = 1'h1, MONITOR_MODE = 1'h0;
    logic EMULATION_MODE = 1'h0, WAIT_EXIT = 1'h0, LOW_POWER = 1'h0;
    logic [7:0] PADDR = 8'h00, FORCED_OPCODE, rd;
    logic [31:0] PWDATA = 32'h0, PRDATA;
    logic [15:0] CPU_ADDR = 16'h0000, BREAK_VECTOR;
    logic CPU_INSTR_START, CPU_RTI_DONE, PREADY, PSLVERR, err, FORCE_SWI;
    logic BREAKPOINT_REQUEST, BREAK_STATE, TIMER_HALT, WATCHDOG_HOLD;
    logic STATUS_CLEAR_ALLOWED;
    int bad_count = 0, check_count = 0;
    bkpu_breakpoint_unit bkpu_breakpoint_unit_inst (.SYS_CLK, .RSTN, .PSEL,
        .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
        .CPU_ADDR, .CPU_OPCODE_FETCH, .CPU_INSTR_START, .CPU_RTI_DONE,
        .MONITOR_MODE, .EMULATION_MODE, .WAIT_EXIT, .LOW_POWER,
        .BREAKPOINT_REQUEST, .FORCE_SWI, .FORCED_OPCODE, .BREAK_VECTOR,
        .BREAK_STATE, .TIMER_HALT, .WATCHDOG_HOLD, .STATUS_CLEAR_ALLOWED);
    bkpu_cpu_model bkpu_cpu_model_inst (.clk(SYS_CLK), .rst_n(RSTN),
        .force_swi(FORCE_SWI), .ret_dly(8'h14),
        .instr_start(CPU_INSTR_START), .rti_done(CPU_RTI_DONE));
    initial forever #50 SYS_CLK = ~SYS_CLK;
    task automatic tally_and_finish(input logic hung);
        bad_count += int'(hung);
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t seen %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        {PSEL, PWRITE, PADDR, PWDATA} <= {1'h1, wr, a, 24'h0, d};
        @(posedge SYS_CLK) PENABLE <= 1'h1;
        @(posedge SYS_CLK);
        repeat (20) if (PREADY !== 1'h1) @(posedge SYS_CLK);
        if (PREADY !== 1'h1) tally_and_finish(1'h1);
        {rd, err} = {PRDATA[7:0], PSLVERR};
        {PSEL, PENABLE} <= 2'h0;
        @(posedge SYS_CLK);
    endtask : apb
    task automatic expect_break(input logic exp);
        repeat (12) if (BREAKPOINT_REQUEST !== 1'h1) @(posedge SYS_CLK);
        check(BREAKPOINT_REQUEST, exp);
        if (exp && BREAKPOINT_REQUEST !== 1'h1) tally_and_finish(1'h1);
    endtask : expect_break
    // Software side of the handler: reprogram, clear active, await return
    task automatic handler(input logic [7:0] a, d, ctl);
        CPU_ADDR <= 16'h0000;
        apb(1'h1, a, d);
        apb(1'h1, bkpu_pkg::ADDR_STATUS_CONTROL, ctl);
        repeat (60) if (BREAK_STATE === 1'h1) @(posedge SYS_CLK);
        check(BREAK_STATE, 1'h0);
    endtask : handler
    task automatic s_regs;
        for (int i = 0; i < 7; i++) begin
            apb(1'h0, 8'(i * 4), 8'h00);
            check({rd, err}, {8'h00, i == 6});
        end
    endtask : s_regs
    task automatic s_match;
        apb(1'h1, bkpu_pkg::ADDR_ADDRESS_HIGH, 8'h12);
        apb(1'h1, bkpu_pkg::ADDR_ADDRESS_LOW, 8'h34);
        apb(1'h0, bkpu_pkg::ADDR_ADDRESS_HIGH, 8'h00);
        check(rd, 8'h12);
        apb(1'h1, bkpu_pkg::ADDR_STATUS_CONTROL, 8'h80);
        CPU_ADDR <= 16'h1235;
        expect_break(1'h0);
        {LOW_POWER, CPU_ADDR} <= {1'h1, 16'h1234};
        expect_break(1'h0);
        LOW_POWER <= 1'h0;
        expect_break(1'h1);
        check({FORCE_SWI, FORCED_OPCODE}, {1'h1, bkpu_pkg::SWI_OPCODE});
        check(BREAK_VECTOR, bkpu_pkg::VECTOR_NORMAL);
        WAIT_EXIT <= 1'h1;
        @(posedge SYS_CLK) WAIT_EXIT <= 1'h0;
        apb(1'h0, bkpu_pkg::ADDR_WAIT_STATUS, 8'h00);
        check(rd, 8'h00);
        apb(1'h0, bkpu_pkg::ADDR_STATUS_CONTROL, 8'h00);
        check(rd, 8'hC0);
        handler(bkpu_pkg::ADDR_ADDRESS_LOW, 8'h56, 8'h80);
        {CPU_OPCODE_FETCH, CPU_ADDR} <= {1'h0, 16'h1256};
        expect_break(1'h1);
        handler(bkpu_pkg::ADDR_STATUS_CONTROL, 8'h80, 8'h80);
        {CPU_OPCODE_FETCH, CPU_ADDR} <= {1'h1, 16'h1256};
        expect_break(1'h0);
    endtask : s_match
    task automatic s_soft;
        {MONITOR_MODE, EMULATION_MODE, CPU_ADDR} <= {2'h3, 16'h0000};
        apb(1'h1, bkpu_pkg::ADDR_AUXILIARY, 8'h01);
        apb(1'h1, bkpu_pkg::ADDR_STATUS_CONTROL, 8'hC0);
        expect_break(1'h1);
        WAIT_EXIT <= 1'h1;
        @(posedge SYS_CLK) WAIT_EXIT <= 1'h0;
        check(BREAK_VECTOR, bkpu_pkg::VECTOR_MONITOR);
        check({WATCHDOG_HOLD, TIMER_HALT}, 2'h3);
        check(STATUS_CLEAR_ALLOWED, 1'h0);
        apb(1'h0, bkpu_pkg::ADDR_WAIT_STATUS, 8'h00);
        check(rd, 8'h02);
        apb(1'h1, bkpu_pkg::ADDR_FLAG_CONTROL, 8'h80);
        @(posedge SYS_CLK);
        check(STATUS_CLEAR_ALLOWED, 1'h1);
        apb(1'h0, bkpu_pkg::ADDR_FLAG_CONTROL, 8'h00);
        check(rd, 8'h80);
        handler(bkpu_pkg::ADDR_ADDRESS_LOW, 8'h78, 8'h00);
        CPU_ADDR <= 16'h1278;
        expect_break(1'h0);
    endtask : s_soft
    initial begin
        repeat (8) @(posedge SYS_CLK);
        RSTN <= 1'h1;
        repeat (3) @(posedge SYS_CLK);
        s_regs;
        s_match;
        s_soft;
        tally_and_finish(1'h0);
    end
endmodule : tb
`default_nettype wire
